// [abort_fault_defines.vh]
// Constants for the abort and fault classification unit.
`ifndef ABORT_FAULT_DEFINES_VH
`define ABORT_FAULT_DEFINES_VH

// Avalon register word offsets, decoded from address bits 5:2.
`define REG_CTRL 4'h0
`define REG_IFS 4'h1
`define REG_IFA 4'h2
`define REG_IAFS 4'h3
`define REG_DFS 4'h4
`define REG_DFA 4'h5
`define REG_DAFS 4'h6
`define REG_LINK 4'h7
`define REG_SAVED 4'h8
`define ADDR_HI 5
`define ADDR_LO 2

// Control register fields.
`define CTRL_ECC_LO 0
`define CTRL_ECC_HI 1
`define CTRL_MONITOR 2
`define CTRL_TCM_ERR_EN 3

// Parity/ECC handling modes.
`define ECC_IGNORE 2'h0
`define ECC_ABORT 2'h1
`define ECC_CORRECT 2'h2
`define ECC_CORR_ABORT 2'h3

// Fault status encodings.
`define FS_NONE 5'h00
`define FS_MPU 5'h0D
`define FS_SYNC_EXT 5'h08
`define FS_ASYNC_EXT 5'h16
`define FS_SYNC_PAR 5'h19
`define FS_ASYNC_PAR 5'h18
`define FS_DEBUG 5'h02
`define FS_WNR_BIT 11
`define FS_EXT_BIT 10

// Aux fault status fields.
`define AUX_RECOV_BIT 21
`define AUX_SRC_LO 22
`define AUX_WAY_LO 26
`define AUX_SET_LO 5

// Error source codes.
`define SRC_CACHE 3'h0
`define SRC_AXIM 3'h1
`define SRC_AXIP 3'h2
`define SRC_AHBP 3'h3
`define SRC_TCMA 3'h4
`define SRC_TCMB 3'h5

// Bus response codes.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3

`endif

// [abort_fault_handler.v]
// Abort classification and fault status recording for the core pipeline.
// Contract
// (RULE_01) Protection faults synchronous, highest priority
// (RULE_02) Protection fault blocks outgoing bus transaction
// (RULE_03) Bus error on loads/fetch/exclusive/ordered: synchronous
// (RULE_04) Bus error on plain store: asynchronous
// (RULE_05) OKAY to exclusive read counts as error
// (RULE_06) Unsupported shared exclusives aborted as error
// (RULE_07) Peripheral bus ERROR equals slave error
// (RULE_08) Software selects parity/ECC handling mode
// (RULE_09) Debug halt turns silent correction into abort
// (RULE_10) Load/TCM-store ECC sync; cache store async
// (RULE_11) Memory error abort only on commit
// (RULE_12) Fixable errors always flagged correctable
// (RULE_13) Enabled TCM external error aborts or slave-errors
// (RULE_14) TCM write errors async, read errors sync
// (RULE_15) Retry repeats operation; retry is recoverable
// (RULE_16) Monitor debug events raise an abort
// (RULE_17) Abort loads link register with resume address
// (RULE_18) Abort saves state into saved status
// (RULE_19) Fault status records type and direction
// (RULE_20) Synchronous abort records fault address
// (RULE_21) Sync aux status: recoverable, source, way only
// (RULE_22) Async aux status: set and way; address kept
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "abort_fault_defines.vh"

module abort_fault_handler (
  input wire clk,
  input wire reset,
  // Avalon-MM register slave.
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Access under check, one cycle per access.
  input wire acc_valid,
  input wire acc_is_instr,
  input wire acc_is_write,
  input wire acc_exclusive,
  input wire acc_strongly_ordered,
  input wire acc_in_tcm,
  input wire acc_periph,
  input wire acc_noncache,
  input wire acc_cache_miss,
  input wire acc_commit,
  input wire acc_speculative,
  input wire acc_cache_maint,
  input wire [31:0] acc_addr,
  input wire [31:0] acc_instr_addr,
  input wire [31:0] acc_cpu_state,
  // Protection unit outcome.
  input wire prot_fault,
  // Bus request from the pipeline and its gated copy.
  input wire bus_req_in,
  output wire bus_req_out,
  // Bus response.
  input wire bus_resp_valid,
  input wire [1:0] bus_resp,
  input wire bus_resp_ahb,
  input wire bus_resp_periph,
  input wire ahb_error,
  input wire excl_unsupported,
  // Parity/ECC detection.
  input wire ram_err,
  input wire ram_err_fixable,
  input wire ram_err_in_cache,
  input wire ram_err_tcm_b,
  input wire [1:0] ram_err_way,
  input wire [15:0] ram_err_set,
  // External TCM port error.
  input wire tcm_ext_err,
  input wire tcm_ext_retry,
  input wire tcm_ext_b,
  input wire tcm_slave_access,
  output reg tcm_slave_slverr,
  // Debug.
  input wire debug_halted,
  input wire dbg_breakpoint,
  input wire dbg_vector_catch,
  input wire dbg_watchpoint,
  input wire dbg_breakpoint_instruction,
  // Outcome to the pipeline.
  output reg sync_abort,
  output reg async_abort,
  output reg retry_op,
  output reg correct_err,
  output reg correctable_fault,
  output reg err_event_detect,
  output reg err_event_abort
);

  // Software control register.
  reg [31:0] ctrl_ff;
  // High in the second cycle of a read, once read data has been registered.
  reg rd_done_ff;
  // Fault recording registers.
  reg [31:0] instr_fault_status_ff;
  reg [31:0] instr_fault_address_ff;
  reg [31:0] instr_aux_fault_status_ff;
  reg [31:0] data_fault_status_ff;
  reg [31:0] data_fault_address_ff;
  reg [31:0] data_aux_fault_status_ff;
  reg [31:0] abort_link_register_ff;
  reg [31:0] abort_saved_status_ff;

  // Build an auxiliary status word from its fields.
  function [31:0] aux_word;
    input recov;
    input [2:0] src;
    input [1:0] way;
    input [15:0] set;
    begin
      aux_word = 32'h00000000;
      aux_word[`AUX_RECOV_BIT] = recov;
      aux_word[`AUX_SRC_LO +: 3] = src;
      aux_word[`AUX_WAY_LO +: 2] = way;
      aux_word[`AUX_SET_LO +: 16] = set;
    end
  endfunction

  // Build a fault status word from type and direction.
  function [31:0] fs_word;
    input [4:0] code;
    input wnr;
    begin
      fs_word = 32'h00000000;
      fs_word[3:0] = code[3:0];
      fs_word[`FS_EXT_BIT] = code[4];
      fs_word[`FS_WNR_BIT] = wnr;
    end
  endfunction

  wire [1:0] ecc_mode = ctrl_ff[`CTRL_ECC_HI:`CTRL_ECC_LO];
  wire monitor_mode = ctrl_ff[`CTRL_MONITOR];
  wire tcm_err_en = ctrl_ff[`CTRL_TCM_ERR_EN];

  // Outbound bus requests are suppressed for protection faults off the TCMs on peripheral, non-cacheable or cache-miss accesses.
  assign bus_req_out = bus_req_in & ~(prot_fault & ~acc_in_tcm &
    (acc_periph | acc_noncache | acc_cache_miss)); // RULE_02

  // A read waits one cycle so that registered read data already stands at the
  // edge where the master sees waitrequest low; writes are taken at once.
  assign avs_waitrequest = avs_read & ~rd_done_ff;

  // Classification of the current access.
  reg nxt_sync;
  reg nxt_async;
  reg nxt_retry;
  reg nxt_correct;
  reg nxt_debug;
  reg nxt_recov;
  reg [2:0] nxt_src;
  reg [4:0] nxt_code;
  reg nxt_ram_err; // The abort comes from a parity/ECC error.
  reg ext_err;
  reg ext_sync;
  reg ram_abort;
  reg ram_live;
  reg tcm_live;

  // Priority: protection, debug, retry, external, TCM external, parity/ECC.
  always @* begin
    nxt_sync = 1'b0;
    nxt_async = 1'b0;
    nxt_retry = 1'b0;
    nxt_correct = 1'b0;
    nxt_debug = 1'b0;
    nxt_recov = 1'b0;
    nxt_src = `SRC_CACHE;
    nxt_code = `FS_NONE;
    nxt_ram_err = 1'b0;
    // Bus errors, including the cases treated as slave error.
    ext_err = (bus_resp_valid & ((bus_resp == `RESP_SLVERR) | (bus_resp == `RESP_DECERR)
      | (bus_resp_ahb & ahb_error) // RULE_07
      | (acc_exclusive & ~acc_is_write & (bus_resp == `RESP_OKAY)))) // RULE_05
      // Unsupported shared exclusives are aborted here; no response is awaited.
      | (acc_exclusive & excl_unsupported & bus_resp_periph); // RULE_06
    ext_sync = ~acc_is_write | acc_is_instr | acc_exclusive | acc_strongly_ordered; // RULE_03
    // Speculative accesses ignore memory errors; aborts wait for commit.
    ram_live = ram_err & acc_commit & ~acc_speculative; // RULE_11
    tcm_live = tcm_ext_err & tcm_err_en & acc_commit & ~acc_speculative & ~tcm_slave_access;
    // Mode decides abort and correction; debug halt forces abort in the correct-only mode.
    ram_abort = (ecc_mode == `ECC_ABORT) | (ecc_mode == `ECC_CORR_ABORT) |
      ((ecc_mode == `ECC_CORRECT) & debug_halted); // RULE_08 RULE_09
    if (acc_valid) begin
      if (prot_fault) begin
        nxt_sync = 1'b1; // RULE_01
        nxt_code = `FS_MPU;
      end else if (monitor_mode & (dbg_breakpoint | dbg_vector_catch | dbg_watchpoint |
          dbg_breakpoint_instruction)) begin
        nxt_sync = 1'b1; // RULE_16
        nxt_debug = 1'b1;
        nxt_code = `FS_DEBUG;
      end else if (tcm_live & tcm_ext_retry & ~acc_is_write) begin
        nxt_retry = 1'b1; // RULE_15
      end else if (ext_err) begin
        nxt_sync = ext_sync; // RULE_03
        nxt_async = ~ext_sync; // RULE_04
        nxt_src = bus_resp_ahb ? `SRC_AHBP : (bus_resp_periph ? `SRC_AXIP : `SRC_AXIM);
        nxt_code = ext_sync ? `FS_SYNC_EXT : `FS_ASYNC_EXT;
      end else if (tcm_live) begin
        nxt_sync = ~acc_is_write; // RULE_13 RULE_14
        nxt_async = acc_is_write; // RULE_14
        nxt_src = tcm_ext_b ? `SRC_TCMB : `SRC_TCMA;
        nxt_code = acc_is_write ? `FS_ASYNC_EXT : `FS_SYNC_EXT;
      end else if (ram_live & (ecc_mode != `ECC_IGNORE)) begin
        nxt_correct = ram_err_fixable & (ecc_mode != `ECC_ABORT);
        nxt_recov = ram_err_fixable; // RULE_15
        nxt_src = ram_err_in_cache ? `SRC_CACHE : (ram_err_tcm_b ? `SRC_TCMB : `SRC_TCMA);
        if (ram_abort) begin
          nxt_ram_err = 1'b1;
          // Cache stores and maintenance are asynchronous, the rest synchronous.
          if (ram_err_in_cache & (acc_is_write | acc_cache_maint)) begin
            nxt_async = 1'b1; // RULE_10
            nxt_code = `FS_ASYNC_PAR;
          end else begin
            nxt_sync = 1'b1; // RULE_10
            nxt_code = `FS_SYNC_PAR;
          end
        end
      end
    end
  end

  // Registered outcome pulses and event outputs.
  always @(posedge clk) begin
    if (reset) begin
      sync_abort <= 1'b0;
      async_abort <= 1'b0;
      retry_op <= 1'b0;
      correct_err <= 1'b0;
      correctable_fault <= 1'b0;
      err_event_detect <= 1'b0;
      err_event_abort <= 1'b0;
      tcm_slave_slverr <= 1'b0;
    end else begin
      sync_abort <= nxt_sync;
      async_abort <= nxt_async;
      retry_op <= nxt_retry;
      correct_err <= nxt_correct;
      // Fixable errors are flagged whatever the mode.
      correctable_fault <= ram_err & ram_err_fixable; // RULE_12
      // Detection event fires even without commit; abort event only with abort.
      err_event_detect <= ram_err; // RULE_11
      err_event_abort <= (nxt_sync | nxt_async) & nxt_ram_err; // RULE_11
      // Slave-port TCM errors answer with a slave error instead of an abort.
      tcm_slave_slverr <= tcm_ext_err & tcm_err_en & tcm_slave_access; // RULE_13
    end
  end

  wire take_abort = nxt_sync | nxt_async;
  wire is_instr_side = acc_is_instr & ~nxt_async;
  // Cache location is only meaningful for a cache parity/ECC abort.
  wire cache_loc = nxt_ram_err & ram_err_in_cache;
  wire [1:0] cache_way = cache_loc ? ram_err_way : 2'h0;

  // Fault recording and software-written control register.
  always @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= 32'h00000000;
      instr_fault_status_ff <= 32'h00000000;
      instr_fault_address_ff <= 32'h00000000;
      instr_aux_fault_status_ff <= 32'h00000000;
      data_fault_status_ff <= 32'h00000000;
      data_fault_address_ff <= 32'h00000000;
      data_aux_fault_status_ff <= 32'h00000000;
      abort_link_register_ff <= 32'h00000000;
      abort_saved_status_ff <= 32'h00000000;
    end else begin
      // Only the control register is writable; a write hitting an abort
      // cycle cannot collide because the fault registers are read-only.
      if (avs_write && avs_address[`ADDR_HI:`ADDR_LO] == `REG_CTRL) begin
        if (avs_byteenable[0]) begin
          ctrl_ff[7:0] <= avs_writedata[7:0];
        end
      end
      if (take_abort) begin
        abort_link_register_ff <= acc_instr_addr; // RULE_17
        abort_saved_status_ff <= acc_cpu_state; // RULE_18
        if (is_instr_side) begin
          instr_fault_status_ff <= fs_word(nxt_code, 1'b0); // RULE_19
        end else begin
          data_fault_status_ff <= fs_word(nxt_code, acc_is_write); // RULE_19
        end
      end
      if (nxt_sync) begin
        // Debug events record the address but leave aux status alone.
        if (is_instr_side) begin
          instr_fault_address_ff <= acc_addr; // RULE_20
          if (!nxt_debug) begin
            instr_aux_fault_status_ff <= aux_word(nxt_recov, nxt_src,
              cache_way, 16'h0000); // RULE_21
          end
        end else begin
          data_fault_address_ff <= acc_addr; // RULE_20
          if (!nxt_debug) begin
            data_aux_fault_status_ff <= aux_word(nxt_recov, nxt_src,
              cache_way, 16'h0000); // RULE_21
          end
        end
      end
      if (nxt_async) begin
        // Address register is left as it was.
        data_aux_fault_status_ff <= aux_word(nxt_recov, nxt_src,
          cache_way,
          cache_loc ? ram_err_set : 16'h0000); // RULE_22
      end
    end
  end

  // Read data decode; unmapped addresses read zero. Data is registered in the
  // first cycle of a read and stands unchanged through the accepting edge.
  always @(posedge clk) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
      rd_done_ff <= 1'b0;
    end else begin
      rd_done_ff <= avs_waitrequest;
      if (avs_waitrequest) begin
        case (avs_address[`ADDR_HI:`ADDR_LO])
          `REG_CTRL: avs_readdata <= ctrl_ff;
          `REG_IFS: avs_readdata <= instr_fault_status_ff;
          `REG_IFA: avs_readdata <= instr_fault_address_ff;
          `REG_IAFS: avs_readdata <= instr_aux_fault_status_ff;
          `REG_DFS: avs_readdata <= data_fault_status_ff;
          `REG_DFA: avs_readdata <= data_fault_address_ff;
          `REG_DAFS: avs_readdata <= data_aux_fault_status_ff;
          `REG_LINK: avs_readdata <= abort_link_register_ff;
          `REG_SAVED: avs_readdata <= abort_saved_status_ff;
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// [fabric_model.sv]
// Behavioural bus fabric that answers the classifier's gated requests.
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
  input wire logic clk,
  input wire logic req,
  input wire logic en,
  input wire logic [1:0] code,
  output logic valid,
  output logic [1:0] resp
);
  logic [1:0] last_ff = 2'h0; // Last code seen on the response lines.
  // Only a request that really left the block is answered.
  assign valid = req & en;
  // A slave without exclusive support may answer OKAY; idle lines keep flipping.
  assign resp = valid ? code : ~last_ff;
  // Track the lines so an idle bus never repeats a stale code.
  always @(posedge clk) begin
    last_ff <= resp;
  end
endmodule
`default_nettype wire

// [afh_sva.sv]
// Concurrent checks on the abort classifier's ports.
`timescale 1ns/1ps
`default_nettype none
module afh_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic acc_valid,
  input wire logic acc_is_write,
  input wire logic acc_exclusive,
  input wire logic acc_strongly_ordered,
  input wire logic acc_in_tcm,
  input wire logic acc_periph,
  input wire logic acc_noncache,
  input wire logic acc_cache_miss,
  input wire logic acc_speculative,
  input wire logic prot_fault,
  input wire logic bus_req_in,
  input wire logic bus_req_out,
  input wire logic bus_resp_valid,
  input wire logic [1:0] bus_resp,
  input wire logic ahb_error,
  input wire logic excl_unsupported,
  input wire logic tcm_ext_retry,
  input wire logic dbg_breakpoint,
  input wire logic dbg_vector_catch,
  input wire logic dbg_watchpoint,
  input wire logic dbg_breakpoint_instruction,
  input wire logic sync_abort,
  input wire logic async_abort
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // A debug event outranks bus errors, so it is excluded below.
  logic dbg;
  assign dbg = dbg_breakpoint | dbg_vector_catch | dbg_watchpoint | dbg_breakpoint_instruction;
  // A bus error with nothing of higher rank in the same cycle.
  logic berr;
  assign berr = acc_valid & !prot_fault & !dbg & !tcm_ext_retry & bus_resp_valid & bus_resp[1];
  sequence s_prot;
    acc_valid && prot_fault;
  endsequence
  a_prot_sync: assert property (s_prot |=> sync_abort && !async_abort)
    else $error("protection fault not a synchronous abort");
  a_bus_gate: assert property (prot_fault && !acc_in_tcm &&
    (acc_periph || acc_noncache || acc_cache_miss) |-> !bus_req_out)
    else $error("faulted access reached the bus");
  a_bus_pass: assert property (!prot_fault |-> bus_req_out == bus_req_in)
    else $error("clean request not passed on");
  a_load_sync: assert property (berr && !acc_is_write |=> sync_abort)
    else $error("bus error on a read not synchronous");
  a_store_async: assert property (berr && acc_is_write && !acc_exclusive &&
    !acc_strongly_ordered |=> async_abort && !sync_abort)
    else $error("bus error on a plain store not asynchronous");
  a_spec_quiet: assert property (acc_valid && acc_speculative && !prot_fault && !dbg &&
    !bus_resp_valid && !ahb_error && !excl_unsupported |=> !sync_abort && !async_abort)
    else $error("speculative access raised an abort");
  a_idle_quiet: assert property (!acc_valid |=> !sync_abort && !async_abort)
    else $error("abort without an access");
  a_one_kind: assert property (!(sync_abort && async_abort))
    else $error("abort both synchronous and asynchronous");
  a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
    else $error("register write stalled");
  a_read_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("register read stalled beyond one cycle");
endmodule
bind abort_fault_handler afh_sva chk (.*);
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the abort classifier.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, acc_addr = 32'h0, acc_instr_addr = 32'h0;
  logic [31:0] acc_cpu_state = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [1:0] ram_err_way = 2'h2, bus_resp, rcode = 2'h0;
  logic [15:0] ram_err_set = 16'h0ABC;
  logic ren, acc_valid, acc_is_instr, acc_is_write, acc_exclusive, acc_strongly_ordered;
  logic acc_in_tcm, acc_periph, acc_noncache, acc_cache_miss, acc_commit, acc_speculative;
  logic acc_cache_maint, prot_fault, bus_req_in, bus_resp_ahb, bus_resp_periph, ahb_error;
  logic excl_unsupported, ram_err, ram_err_fixable, ram_err_in_cache, ram_err_tcm_b;
  logic tcm_ext_err, tcm_ext_retry, tcm_ext_b, tcm_slave_access, debug_halted, dbg_breakpoint;
  logic dbg_vector_catch, dbg_watchpoint, dbg_breakpoint_instruction, bus_req_out;
  logic bus_resp_valid, tcm_slave_slverr, sync_abort, async_abort, retry_op, correct_err;
  logic correctable_fault, err_event_detect, err_event_abort;
  logic [4:0] o; // Outcome pulses packed for comparison.
  logic [31:0] v = 32'h0; // One bit per access flag; bit 31 enables a bus answer.
  int errors = 0, n_compared = 0;
  logic [31:0] rdata = 32'h0; // Read data taken at the accepting edge.
  localparam logic [31:0] MT = 32'h800; // Cache maintenance operation.
  localparam logic [31:0] VA = 32'h1, IN = 32'h2, WR = 32'h4, EX = 32'h8, SO = 32'h10;
  localparam logic [31:0] TC = 32'h20, PE = 32'h40, NC = 32'h80, CM = 32'h200, SP = 32'h400;
  localparam logic [31:0] PF = 32'h1000, RQ = 32'h2000, AH = 32'h4000, BP = 32'h8000;
  localparam logic [31:0] AE = 32'h1_0000, XU = 32'h2_0000, RE = 32'h4_0000, FX = 32'h8_0000;
  localparam logic [31:0] IC = 32'h10_0000, TE = 32'h40_0000, TR = 32'h80_0000;
  localparam logic [31:0] TS = 32'h200_0000, DH = 32'h400_0000, RN = 32'h8000_0000;
  assign {ren, dbg_breakpoint_instruction, dbg_watchpoint, dbg_vector_catch, dbg_breakpoint,
    debug_halted, tcm_slave_access, tcm_ext_b, tcm_ext_retry, tcm_ext_err, ram_err_tcm_b,
    ram_err_in_cache, ram_err_fixable, ram_err, excl_unsupported, ahb_error, bus_resp_periph,
    bus_resp_ahb, bus_req_in, prot_fault, acc_cache_maint, acc_speculative, acc_commit,
    acc_cache_miss, acc_noncache, acc_periph, acc_in_tcm, acc_strongly_ordered, acc_exclusive,
    acc_is_write, acc_is_instr, acc_valid} = v;
  assign o = {sync_abort, async_abort, retry_op, correct_err, correctable_fault};
  abort_fault_handler dut (.*);
  fabric_model far (.clk(clk), .req(bus_req_out), .en(ren), .code(rcode),
    .valid(bus_resp_valid), .resp(bus_resp));
  // Free-running 20 MHz clock.
  initial forever #25 clk = ~clk;
  // Count and report one comparison.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One register access; the request is held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Read data is taken at the edge at which waitrequest is seen low.
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask
  // Present one access for one cycle; outcome pulses are settled on return.
  task automatic go(input logic [31:0] f, input logic [1:0] c, input logic [31:0] a);
    @(posedge clk);
    v <= f;
    rcode <= c;
    acc_addr <= a;
    acc_instr_addr <= ~a;
    acc_cpu_state <= a ^ 32'h0000_00D3;
    @(posedge clk);
    v <= 32'h0;
    #1;
  endtask
  // Single exit point for both normal end and watchdog.
  task automatic end_of_test;
    $display("errors %0d n_compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // The whole sequence needs well under 200 cycles; the margin is generous.
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(6'h00, 32'h0);
    bus(1'b1, 6'h10, 32'hFFFF_FFFF);
    rd(6'h10, 32'h0);
    rd(6'h3C, 32'h0);
    go(VA | PF | RQ | NC | CM | RN, 2'h2, 32'h1000);
    chk(o, 5'h10);
    rd(6'h10, 32'h00D);
    rd(6'h14, 32'h1000);
    rd(6'h1C, 32'hFFFF_EFFF);
    rd(6'h20, 32'h10D3);
    go(VA | RQ | CM | RN, 2'h2, 32'h2000);
    chk(o, 5'h10);
    go(VA | IN | RQ | CM | RN, 2'h3, 32'h2004);
    chk(o, 5'h10);
    rd(6'h04, 32'h008);
    rd(6'h08, 32'h2004);
    rd(6'h0C, 32'h0040_0000);
    go(VA | WR | EX | RQ | CM | RN, 2'h2, 32'h2008);
    chk(o, 5'h10);
    go(VA | WR | SO | RQ | CM | RN, 2'h3, 32'h200C);
    chk(o, 5'h10);
    go(VA | RQ | CM | AH | AE | RN, 2'h0, 32'h3000);
    chk(o, 5'h10);
    rd(6'h10, 32'h008);
    rd(6'h18, 32'h00C0_0000);
    go(VA | EX | RQ | CM | RN, 2'h0, 32'h3100);
    chk(o, 5'h10);
    go(VA | EX | PE | RQ | CM | BP | XU, 2'h0, 32'h3300);
    chk(o, 5'h10);
    go(VA | WR | RQ | CM | RN, 2'h3, 32'h4000);
    chk(o, 5'h08);
    rd(6'h10, 32'hC06);
    rd(6'h14, 32'h3300);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 6'h00, m);
      go(VA | CM | RE | FX | IC, 2'h0, 32'h5000);
      chk(o, {m[0], 1'h0, 1'h0, m[1], 1'h1});
    end
    bus(1'b1, 6'h00, 32'h2);
    go(VA | CM | RE | FX | IC | DH, 2'h0, 32'h5004);
    chk(o[4], 1'h1);
    bus(1'b1, 6'h00, 32'h1);
    go(VA | WR | CM | RE | IC, 2'h0, 32'h5008);
    chk(o, 5'h08);
    chk({err_event_detect, err_event_abort}, 2'h3);
    go(VA | MT | CM | RE | IC, 2'h0, 32'h5008);
    chk(o, 5'h08);
    rd(6'h18, 32'h0801_5780);
    go(VA | WR | TC | CM | RE, 2'h0, 32'h500C);
    chk(o, 5'h10);
    rd(6'h18, 32'h0100_0000);
    go(VA | SP | RE | IC, 2'h0, 32'h5010);
    chk(o, 5'h00);
    chk({err_event_detect, err_event_abort}, 2'h2);
    go(VA | TC | CM | TE, 2'h0, 32'h6000);
    chk(o, 5'h00);
    bus(1'b1, 6'h00, 32'h8);
    go(VA | TC | CM | TE, 2'h0, 32'h6004);
    chk(o, 5'h10);
    go(VA | WR | TC | CM | TE, 2'h0, 32'h6008);
    chk(o, 5'h08);
    go(VA | TC | CM | TE | TR, 2'h0, 32'h600C);
    chk(o, 5'h04);
    go(TS | TE, 2'h0, 32'h6010);
    chk(tcm_slave_slverr, 1'h1);
    bus(1'b1, 6'h00, 32'h4);
    for (int i = 0; i < 4; i++) begin
      go(VA | CM | (32'h800_0000 << i), 2'h0, 32'h7000);
      chk(o, 5'h10);
    end
    end_of_test;
  end
endmodule
`default_nettype wire
